// ---- sensor_ctrl_consts.svh ----
/*
  Constants of the sensor control register bank: serial ids, register offsets,
  reset values, writable-bit masks and frame timing counts.
  Assumes it is included once per compilation unit by its bare name.
*/
`ifndef SENSOR_CTRL_CONSTS_SVH
`define SENSOR_CTRL_CONSTS_SVH

// ==================================================
// serial bus identities
`define SCCB_WR_ID 8'h60
`define SCCB_RD_ID 8'h61

// ==================================================
// register offsets
`define REG_GAIN_LOW 8'h00
`define REG_BLUE_GAIN 8'h01
`define REG_RED_GAIN 8'h02
`define REG_VWIN_LOW 8'h03
`define REG_ROW_SKIP 8'h04
`define REG_BLUE_AVG 8'h05
`define REG_GB_Y_AVG 8'h06
`define REG_GR_AVG 8'h07
`define REG_RED_AVG 8'h08
`define REG_SLEEP_DRV 8'h09
`define REG_PID_HIGH 8'h0a

// ==================================================
// reset values and writable masks
`define RST_GAIN_LOW 8'h00
`define RST_CH_GAIN 8'h80
`define RST_VWIN_LOW 8'h12
`define RST_ROW_SKIP 8'h00
`define RST_AVG 8'h00
`define RST_SLEEP_DRV 8'h01
// arbitrary identity value
`define PID_HIGH_VAL 8'h5a
`define ROW_SKIP_WMASK 8'h4f
`define SLEEP_DRV_WMASK 8'h13

// ==================================================
// field positions
`define SKIP_HI 3
`define SKIP_LO 2
`define SLEEP_BIT 4

// ==================================================
// frame timing in pixel periods and lines
`define SXGA_LINE_TP 11'd1520
`define SXGA_COLS 11'd1280
`define SXGA_LINES 11'd1050
`define SXGA_ROWS 11'd1024
`define VGA_LINE_TP 11'd800
`define VGA_COLS 11'd640
`define VGA_LINES 11'd500
`define VGA_ROWS 11'd480
`define VSYNC_LINES 11'd4
`define FIRST_ROW_LINE 11'd8

`endif

// ---- sensor_ctrl_pkg.sv ----
/*
  Types of the sensor control register bank: serial states, register set,
  output carriers and the module state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sensor_ctrl_pkg;

    // ==================================================
    // serial slave states
    typedef enum logic [3:0] {
        st_idle, st_id, st_id_ack, st_sub, st_sub_ack,
        st_wdata, st_wdata_ack, st_rdata, st_rack
    } sccb_state_e;

    // ==================================================
    // register set
    typedef struct packed {
        logic [7:0] gain_low_byte;
        logic [7:0] blue_channel_gain;
        logic [7:0] red_channel_gain;
        logic [7:0] vertical_window_low_bits;
        logic [7:0] row_skip_format_ctrl;
        logic [7:0] blue_u_average;
        logic [7:0] green_b_y_average;
        logic [7:0] green_r_average;
        logic [7:0] red_v_average;
        logic [7:0] sleep_drive_ctrl;
    } regs_s;

    // ==================================================
    // output carriers
    typedef struct packed {
        logic frame_sync;
        logic line_valid;
        logic pix_valid;
        logic [9:0] data;
    } pix_out_s;

    typedef struct packed {
        logic [9:0] gain_word;
        logic [7:0] blue_gain;
        logic [7:0] red_gain;
        logic [1:0] exposure_low;
        logic [2:0] vend_low;
        logic [2:0] vstart_low;
        logic ccir656_en;
        logic sleep;
        logic [2:0] drive_mult;
    } ctrl_out_s;

    // ==================================================
    // whole module state
    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_p;
        logic sda_m;
        logic sda_s;
        logic sda_p;
        sccb_state_e st;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] sub;
        logic rd;
        logic nack;
        logic oe;
        regs_s regs;
        logic half;
        logic [10:0] col;
        logic [10:0] line;
        pix_out_s pix;
    } state_s;

endpackage : sensor_ctrl_pkg

// ---- sensor_ctrl_regs_frame_out.sv ----
/*
  Sensor control register bank behind a two-wire serial control slave, plus
  the output pixel-stream framer for full-resolution and VGA sizes.
  Assumes sio_c/sio_d come from pins (resynchronised here), and that fmt_raw,
  size_vga and pix_in come from sensor logic on sys_clk.
*/
// Behaviour
// - answer serial bus at write id 0x60 and read id 0x61.
// - single-bit controls: stored one enables, stored zero disables.
// - ten-bit gain word from register 0x00 plus window register bits 7:6.
// - blue and red gains are eight-bit read/write, reset 0x80.
// - row-skip field gates line_valid per skip mode and data format.
// - row-skip register bits 1:0 are exposure word low bits.
// - average registers refresh automatically per output format.
// - sleep bit set enters soft sleep, cleared resumes.
// - drive bits select 1x, 2x, 2x, 4x; register resets 0x01.
// - offset 0x0a is read-only identity high byte; writes ignored.
// - pixel period is one clock for raw, two for YUV/RGB.
// - full resolution gives rows 0..1023, pixels 0..1279 under line_valid.
// - VGA gives rows 0..479, pixels 0..639 under line_valid.
`timescale 1ns/1ps
`include "sensor_ctrl_consts.svh"

module sensor_ctrl_regs_frame_out
    import sensor_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sio_c,
    input wire logic sio_d_i,
    output logic sio_d_o,
    output logic sio_d_oe,
    input wire logic fmt_raw,
    input wire logic size_vga,
    input wire logic [9:0] pix_in,
    output pix_out_s pix,
    output ctrl_out_s ctrl
);

    // ==================================================
    // helpers
    function automatic logic [7:0] reg_read(input regs_s r, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `REG_GAIN_LOW) begin
            v = r.gain_low_byte;
        end else if (a == `REG_BLUE_GAIN) begin
            v = r.blue_channel_gain;
        end else if (a == `REG_RED_GAIN) begin
            v = r.red_channel_gain;
        end else if (a == `REG_VWIN_LOW) begin
            v = r.vertical_window_low_bits;
        end else if (a == `REG_ROW_SKIP) begin
            v = r.row_skip_format_ctrl & `ROW_SKIP_WMASK;
        end else if (a == `REG_BLUE_AVG) begin
            v = r.blue_u_average;
        end else if (a == `REG_GB_Y_AVG) begin
            v = r.green_b_y_average;
        end else if (a == `REG_GR_AVG) begin
            v = r.green_r_average;
        end else if (a == `REG_RED_AVG) begin
            v = r.red_v_average;
        end else if (a == `REG_SLEEP_DRV) begin
            v = r.sleep_drive_ctrl & `SLEEP_DRV_WMASK;
        end else if (a == `REG_PID_HIGH) begin
            v = `PID_HIGH_VAL;
        end
        return v;
    endfunction : reg_read

    // slow running average: one sixteenth of the error per sample
    function automatic logic [7:0] avg_step(input logic [7:0] avg, input logic [7:0] px);
        logic signed [9:0] d;
        d = $signed({2'b00, px}) - $signed({2'b00, avg});
        return avg + 8'(d >>> 4);
    endfunction : avg_step

    function automatic logic row_kept(input logic [1:0] skip, input logic raw, input logic [10:0] row);
        logic k;
        k = 1'b1;
        if (skip == 2'b01) begin
            k = raw ? ~row[1] : ~row[0];
        end else if (skip[1]) begin
            k = raw ? (row[2:1] == 2'b00) : (row[1:0] == 2'b00);
        end
        return k;
    endfunction : row_kept

    // ==================================================
    // state
    state_s s_r;
    state_s s_nxt;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sleep;
    logic tick;
    logic [10:0] line_len;
    logic [10:0] cols;
    logic [10:0] lines;
    logic [10:0] rows;
    logic [10:0] row;
    logic in_rows;
    logic lv;

    // only the second and third stages feed edge logic
    assign scl_rise = s_r.scl_s & ~s_r.scl_p;
    assign scl_fall = ~s_r.scl_s & s_r.scl_p;
    assign bus_start = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
    assign bus_stop = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;

    assign sleep = s_r.regs.sleep_drive_ctrl[`SLEEP_BIT];
    // a raw pixel period is one clock, a YUV/RGB period is two
    assign tick = fmt_raw | s_r.half;
    assign line_len = size_vga ? `VGA_LINE_TP : `SXGA_LINE_TP;
    assign cols = size_vga ? `VGA_COLS : `SXGA_COLS;
    assign lines = size_vga ? `VGA_LINES : `SXGA_LINES;
    assign rows = size_vga ? `VGA_ROWS : `SXGA_ROWS;
    assign row = s_r.line - `FIRST_ROW_LINE;
    assign in_rows = (s_r.line >= `FIRST_ROW_LINE) && (row < rows);
    assign lv = ~sleep & in_rows & (s_r.col < cols)
        & row_kept(s_r.regs.row_skip_format_ctrl[`SKIP_HI:`SKIP_LO], fmt_raw, row);

    // ==================================================
    // next state
    always_comb begin
        logic wr;
        logic [7:0] rv;
        wr = 1'b0;
        rv = 8'h00;
        s_nxt = s_r;
        s_nxt.scl_m = sio_c;
        s_nxt.scl_s = s_r.scl_m;
        s_nxt.scl_p = s_r.scl_s;
        s_nxt.sda_m = sio_d_i;
        s_nxt.sda_s = s_r.sda_m;
        s_nxt.sda_p = s_r.sda_s;

        // serial slave; bits sampled on clock rise, driven after fall
        if (bus_start) begin
            s_nxt.st = st_id;
            s_nxt.cnt = 4'h0;
            s_nxt.oe = 1'b0;
        end else if (bus_stop) begin
            s_nxt.st = st_idle;
            s_nxt.oe = 1'b0;
        end else if (scl_rise) begin
            case (s_r.st)
                st_id, st_sub, st_wdata: begin
                    s_nxt.shift = {s_r.shift[6:0], s_r.sda_s};
                    s_nxt.cnt = s_r.cnt + 4'h1;
                end
                st_rack: begin
                    s_nxt.nack = s_r.sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (s_r.st)
                st_id: begin
                    if (s_r.cnt == 4'h8) begin
                        if (s_r.shift == `SCCB_WR_ID) begin
                            s_nxt.rd = 1'b0;
                            s_nxt.st = st_id_ack;
                            s_nxt.oe = 1'b1;
                        end else if (s_r.shift == `SCCB_RD_ID) begin
                            s_nxt.rd = 1'b1;
                            s_nxt.st = st_id_ack;
                            s_nxt.oe = 1'b1;
                        end else begin
                            s_nxt.st = st_idle;
                        end
                    end
                end
                st_id_ack: begin
                    s_nxt.cnt = 4'h0;
                    if (s_r.rd) begin
                        rv = reg_read(s_r.regs, s_r.sub);
                        s_nxt.shift = rv;
                        s_nxt.oe = ~rv[7];
                        s_nxt.st = st_rdata;
                    end else begin
                        s_nxt.oe = 1'b0;
                        s_nxt.st = st_sub;
                    end
                end
                st_sub: begin
                    if (s_r.cnt == 4'h8) begin
                        s_nxt.sub = s_r.shift;
                        s_nxt.st = st_sub_ack;
                        s_nxt.oe = 1'b1;
                    end
                end
                st_sub_ack: begin
                    s_nxt.cnt = 4'h0;
                    s_nxt.oe = 1'b0;
                    s_nxt.st = st_wdata;
                end
                st_wdata: begin
                    if (s_r.cnt == 4'h8) begin
                        wr = 1'b1;
                        s_nxt.st = st_wdata_ack;
                        s_nxt.oe = 1'b1;
                    end
                end
                st_wdata_ack: begin
                    s_nxt.cnt = 4'h0;
                    s_nxt.oe = 1'b0;
                    s_nxt.sub = s_r.sub + 8'h01;
                    s_nxt.st = st_wdata;
                end
                st_rdata: begin
                    if (s_r.cnt == 4'h7) begin
                        s_nxt.oe = 1'b0;
                        s_nxt.st = st_rack;
                    end else begin
                        s_nxt.shift = {s_r.shift[6:0], 1'b0};
                        s_nxt.oe = ~s_r.shift[6];
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
                st_rack: begin
                    if (s_r.nack) begin
                        s_nxt.st = st_idle;
                    end else begin
                        rv = reg_read(s_r.regs, s_r.sub + 8'h01);
                        s_nxt.sub = s_r.sub + 8'h01;
                        s_nxt.shift = rv;
                        s_nxt.oe = ~rv[7];
                        s_nxt.cnt = 4'h0;
                        s_nxt.st = st_rdata;
                    end
                end
                default: begin
                end
            endcase
        end

        // frame counters clear to zero and hold there while asleep
        if (sleep) begin
            s_nxt.half = 1'b0;
            s_nxt.col = 11'h000;
            s_nxt.line = 11'h000;
        end else begin
            s_nxt.half = fmt_raw ? 1'b0 : ~s_r.half;
            if (tick) begin
                if (s_r.col == line_len - 11'h001) begin
                    s_nxt.col = 11'h000;
                    s_nxt.line = (s_r.line == lines - 11'h001) ? 11'h000 : s_r.line + 11'h001;
                end else begin
                    s_nxt.col = s_r.col + 11'h001;
                end
            end
        end
        s_nxt.pix.frame_sync = ~sleep & (s_r.line < `VSYNC_LINES);
        s_nxt.pix.line_valid = lv;
        s_nxt.pix.pix_valid = lv & tick;
        s_nxt.pix.data = lv ? pix_in : 10'h000;

        // averages track the format: raw uses the colour mosaic, yuv the U,Y,V,Y order
        if (lv & tick) begin
            if (fmt_raw) begin
                case ({row[0], s_r.col[0]})
                    2'b00: s_nxt.regs.blue_u_average = avg_step(s_r.regs.blue_u_average, pix_in[9:2]);
                    2'b01: s_nxt.regs.green_b_y_average = avg_step(s_r.regs.green_b_y_average, pix_in[9:2]);
                    2'b10: s_nxt.regs.green_r_average = avg_step(s_r.regs.green_r_average, pix_in[9:2]);
                    default: s_nxt.regs.red_v_average = avg_step(s_r.regs.red_v_average, pix_in[9:2]);
                endcase
            end else begin
                case (s_r.col[1:0])
                    2'b00: s_nxt.regs.blue_u_average = avg_step(s_r.regs.blue_u_average, pix_in[9:2]);
                    2'b10: s_nxt.regs.red_v_average = avg_step(s_r.regs.red_v_average, pix_in[9:2]);
                    default: s_nxt.regs.green_b_y_average = avg_step(s_r.regs.green_b_y_average, pix_in[9:2]);
                endcase
            end
        end

        // a host write overrides the running average in the same cycle
        if (wr) begin
            if (s_r.sub == `REG_GAIN_LOW) begin
                s_nxt.regs.gain_low_byte = s_r.shift;
            end else if (s_r.sub == `REG_BLUE_GAIN) begin
                s_nxt.regs.blue_channel_gain = s_r.shift;
            end else if (s_r.sub == `REG_RED_GAIN) begin
                s_nxt.regs.red_channel_gain = s_r.shift;
            end else if (s_r.sub == `REG_VWIN_LOW) begin
                s_nxt.regs.vertical_window_low_bits = s_r.shift;
            end else if (s_r.sub == `REG_ROW_SKIP) begin
                s_nxt.regs.row_skip_format_ctrl = s_r.shift & `ROW_SKIP_WMASK;
            end else if (s_r.sub == `REG_BLUE_AVG) begin
                s_nxt.regs.blue_u_average = s_r.shift;
            end else if (s_r.sub == `REG_GB_Y_AVG) begin
                s_nxt.regs.green_b_y_average = s_r.shift;
            end else if (s_r.sub == `REG_RED_AVG) begin
                s_nxt.regs.red_v_average = s_r.shift;
            end else if (s_r.sub == `REG_SLEEP_DRV) begin
                s_nxt.regs.sleep_drive_ctrl = s_r.shift & `SLEEP_DRV_WMASK;
            end
            // identity and green-r average are read-only, other offsets ignored
        end
    end

    // ==================================================
    // registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.scl_m <= 1'b1;
            s_r.scl_s <= 1'b1;
            s_r.scl_p <= 1'b1;
            s_r.sda_m <= 1'b1;
            s_r.sda_s <= 1'b1;
            s_r.sda_p <= 1'b1;
            s_r.st <= st_idle;
            s_r.regs.gain_low_byte <= `RST_GAIN_LOW;
            s_r.regs.blue_channel_gain <= `RST_CH_GAIN;
            s_r.regs.red_channel_gain <= `RST_CH_GAIN;
            s_r.regs.vertical_window_low_bits <= `RST_VWIN_LOW;
            s_r.regs.row_skip_format_ctrl <= `RST_ROW_SKIP;
            s_r.regs.blue_u_average <= `RST_AVG;
            s_r.regs.green_b_y_average <= `RST_AVG;
            s_r.regs.green_r_average <= `RST_AVG;
            s_r.regs.red_v_average <= `RST_AVG;
            s_r.regs.sleep_drive_ctrl <= `RST_SLEEP_DRV;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==================================================
    // outputs
    assign sio_d_o = 1'b0;
    assign sio_d_oe = s_r.oe;
    assign pix = s_r.pix;
    assign ctrl.gain_word = {s_r.regs.vertical_window_low_bits[7:6], s_r.regs.gain_low_byte};
    assign ctrl.blue_gain = s_r.regs.blue_channel_gain;
    assign ctrl.red_gain = s_r.regs.red_channel_gain;
    assign ctrl.exposure_low = s_r.regs.row_skip_format_ctrl[1:0];
    assign ctrl.vend_low = s_r.regs.vertical_window_low_bits[5:3];
    assign ctrl.vstart_low = s_r.regs.vertical_window_low_bits[2:0];
    assign ctrl.ccir656_en = s_r.regs.row_skip_format_ctrl[6];
    assign ctrl.sleep = sleep;
    // drive multiplier as a plain factor: 1, 2, 2 or 4
    assign ctrl.drive_mult = (s_r.regs.sleep_drive_ctrl[1:0] == 2'b11) ? 3'h4 :
        (s_r.regs.sleep_drive_ctrl[1:0] == 2'b00) ? 3'h1 : 3'h2;

endmodule : sensor_ctrl_regs_frame_out

// ---- sensor_ctrl_regs_frame_out_chk.sv ----
/*
  Port checks for the sensor control bank and pixel framer.
  Assumes one sys_clk domain with synchronous active-high rst.
*/
`timescale 1ns/1ps
module sensor_ctrl_regs_frame_out_chk
    import sensor_ctrl_pkg::*;
(
    input logic sys_clk,
    input logic rst,
    input logic sio_d_oe,
    input logic fmt_raw,
    input logic size_vga,
    input pix_out_s pix,
    input ctrl_out_s ctrl
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ==================================================
    // pixels counted over the current line
    logic [11:0] pv_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (rst || !pix.line_valid) begin
            pv_cnt_r <= 12'h000;
        end else if (pix.pix_valid) begin
            pv_cnt_r <= pv_cnt_r + 12'h001;
        end
    end
    // ==================================================
    // assertions
    a_rst_ctrl: assert property ($fell(rst) |-> ctrl.gain_word == 10'h000 && ctrl.exposure_low == 2'h0
        && ctrl.vend_low == 3'h2 && ctrl.vstart_low == 3'h2) else $error("bad control after reset");
    a_rst_gains: assert property ($fell(rst) |-> ctrl.blue_gain == 8'h80 && ctrl.red_gain == 8'h80)
        else $error("bad gains after reset");
    a_rst_drive: assert property ($fell(rst) |-> ctrl.drive_mult == 3'h2 && !ctrl.sleep && !ctrl.ccir656_en)
        else $error("bad drive after reset");
    a_drive_code: assert property (ctrl.drive_mult == 3'h1 || ctrl.drive_mult == 3'h2 || ctrl.drive_mult == 3'h4)
        else $error("bad drive code");
    a_sleep_quiet: assert property (ctrl.sleep [*3] |-> pix == '0) else $error("stream in sleep");
    a_data_void: assert property (!pix.line_valid |-> pix.data == 10'h000) else $error("data off line");
    a_pv_in_line: assert property (pix.pix_valid |-> pix.line_valid) else $error("pixel off line");
    a_yuv_gap: assert property (pix.pix_valid && !fmt_raw && !$past(fmt_raw) |=> !pix.pix_valid)
        else $error("yuv pixel period");
    a_raw_each: assert property (pix.line_valid && fmt_raw && $past(fmt_raw) |-> pix.pix_valid)
        else $error("raw pixel period");
    a_line_len: assert property ($fell(pix.line_valid) && !ctrl.sleep && !$past(ctrl.sleep)
        |-> pv_cnt_r == (size_vga ? 12'd640 : 12'd1280)) else $error("line length");
    a_sync_blank: assert property (pix.frame_sync |-> !pix.line_valid) else $error("sync over line");
    c_line_end: cover property ($fell(pix.line_valid));
    c_sleep: cover property (ctrl.sleep [*3]);
    c_ack: cover property ($rose(sio_d_oe));
endmodule : sensor_ctrl_regs_frame_out_chk
bind sensor_ctrl_regs_frame_out sensor_ctrl_regs_frame_out_chk i_chk (.sys_clk(sys_clk), .rst(rst),
    .sio_d_oe(sio_d_oe), .fmt_raw(fmt_raw), .size_vga(size_vga), .pix(pix), .ctrl(ctrl));

// ---- serial_host_model.sv ----
/*
  Two-wire control bus host: start, stop and byte transfers.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
`include "sensor_ctrl_consts.svh"
module serial_host_model (
    input logic sys_clk,
    input logic sio_d,
    output logic sio_c,
    output logic host_pull
);
    // ==================================================
    // bit phases of 2 sys_clk give a 200 ns bus clock
    initial begin
        sio_c = 1'b1;
        host_pull = 1'b0;
    end
    task automatic q;
        repeat (2) @(negedge sys_clk);
    endtask : q
    // data moves mid-low and is sampled mid-high, clear of the slave's resync lag
    task automatic bit_io(input logic b, output logic s);
        q();
        host_pull = !b;
        q();
        sio_c = 1'b1;
        q();
        s = sio_d;
        q();
        sio_c = 1'b0;
    endtask : bit_io
    task automatic start_c;
        q();
        host_pull = 1'b1;
        q();
        sio_c = 1'b0;
    endtask : start_c
    task automatic stop_c;
        q();
        host_pull = 1'b1;
        q();
        sio_c = 1'b1;
        q();
        host_pull = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : stop_c
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask : send_byte
    // ==================================================
    // register access; a burst leans on sub-address auto-increment
    task automatic write_regs(input logic [7:0] id, sub, val, input int n, output logic ok);
        logic a;
        start_c();
        send_byte(id, ok);
        send_byte(sub, a);
        ok = ok & a;
        for (int i = 0; i < n; i++) begin
            send_byte(val, a);
            ok = ok & a;
        end
        stop_c(); // register effects only, no image settling wait
    endtask : write_regs
    task automatic read_reg(input logic [7:0] sub, output logic [7:0] d);
        logic a;
        start_c();
        send_byte(`SCCB_WR_ID, a);
        send_byte(sub, a);
        stop_c();
        start_c();
        send_byte(`SCCB_RD_ID, a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, a);
        stop_c();
    endtask : read_reg
endmodule : serial_host_model

// ---- tb_sensor_ctrl_regs_frame_out.sv ----
/*
  Bench for the sensor control bank and pixel framer.
  Assumes the host model and the bound checker sit beside the design.
*/
`timescale 1ns/1ps
`include "sensor_ctrl_consts.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, a, e); end end
module tb_sensor_ctrl_regs_frame_out
    import sensor_ctrl_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic fmt_raw = 1'b1;
    logic size_vga = 1'b1;
    logic [9:0] pix_in = 10'h000;
    logic sio_c, host_pull, sio_d, sio_d_o, sio_d_oe, lv_q;
    pix_out_s pix;
    ctrl_out_s ctrl;
    int num_errors = 0;
    int n_checks = 0;
    int rises = 0;
    int cyc = 0;
    always #12.5 sys_clk = !sys_clk;
    // open-drain wire with pull-up
    assign sio_d = (sio_d_oe ? sio_d_o : 1'b1) & !host_pull;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        lv_q <= pix.line_valid;
        if (pix.line_valid && !lv_q) begin
            rises <= rises + 1;
        end
    end
    sensor_ctrl_regs_frame_out i_dut (.sys_clk(sys_clk), .rst(rst), .sio_c(sio_c), .sio_d_i(sio_d), .sio_d_o(sio_d_o),
        .sio_d_oe(sio_d_oe), .fmt_raw(fmt_raw), .size_vga(size_vga), .pix_in(pix_in), .pix(pix), .ctrl(ctrl));
    serial_host_model i_host (.sys_clk(sys_clk), .sio_d(sio_d), .sio_c(sio_c), .host_pull(host_pull));
    // ==================================================
    // shared tasks
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic raw, vga, output int t0);
        @(negedge sys_clk);
        rst = 1'b1;
        fmt_raw = raw;
        size_vga = vga;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        t0 = cyc;
        rises = 0;
        repeat (4) @(negedge sys_clk);
    endtask : do_reset
    task automatic wr(input logic [7:0] sub, val, input int n, output logic ok);
        i_host.write_regs(`SCCB_WR_ID, sub, val, n, ok);
    endtask : wr
    task automatic rd_chk(input logic [7:0] sub, exp);
        logic [7:0] d;
        i_host.read_reg(sub, d);
        `CHK(d, exp)
    endtask : rd_chk
    // ==================================================
    // scenarios
    task automatic t_reset_map;
        logic [7:0] exp [12] = '{8'h00, 8'h80, 8'h80, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                                 `PID_HIGH_VAL, 8'h00};
        int t0;
        do_reset(1'b1, 1'b1, t0);
        for (int i = 0; i < 12; i++) begin
            rd_chk(8'(i), exp[i]);
        end
    endtask : t_reset_map
    // sleep first, so the average registers keep what the burst wrote
    task automatic t_regs;
        logic [7:0] exp [11] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h4f, 8'hff, 8'hff, 8'h00, 8'hff, 8'h13, `PID_HIGH_VAL};
        logic [2:0] mult [4] = '{3'd1, 3'd2, 3'd2, 3'd4};
        logic ok;
        wr(`REG_SLEEP_DRV, 8'h10, 1, ok);
        rises = 0;
        wr(`REG_GAIN_LOW, 8'hff, 11, ok);
        `CHK(ok, 1'b1)
        `CHK({ctrl.gain_word, ctrl.exposure_low, ctrl.vend_low, ctrl.vstart_low, ctrl.ccir656_en, ctrl.sleep}, 20'hfffff)
        for (int i = 0; i < 11; i++) begin
            rd_chk(8'(i), exp[i]);
        end
        for (int c = 0; c < 4; c++) begin
            wr(`REG_SLEEP_DRV, 8'h10 | 8'(c), 1, ok);
            `CHK(ctrl.drive_mult, mult[c])
        end
        repeat (2000) @(negedge sys_clk);
        `CHK(rises, 0)
        wr(`REG_SLEEP_DRV, 8'h00, 1, ok);
        rises = 0;
        repeat (6800) @(negedge sys_clk);
        `CHK(rises, 1)
        `CHK(ctrl.sleep, 1'b0)
    endtask : t_regs
    task automatic t_bad_id;
        logic ok;
        i_host.write_regs(8'h42, 8'h00, 8'h00, 0, ok);
        `CHK(ok, 1'b0)
        wr(8'h00, 8'h00, 0, ok);
        `CHK(ok, 1'b1)
    endtask : t_bad_id
    // eight rows of raw VGA for each of skip codes 0, 1 and 2, counted from reset release
    task automatic t_skip;
        int exp [3] = '{8, 4, 2};
        int t0;
        logic ok;
        logic [7:0] d;
        pix_in = 10'h3fc;
        for (int k = 0; k < 3; k++) begin
            do_reset(1'b1, 1'b1, t0);
            wr(`REG_ROW_SKIP, 8'(k << 2), 1, ok);
            while (cyc - t0 < 12790) @(negedge sys_clk);
            `CHK(rises, exp[k])
        end
        i_host.read_reg(`REG_BLUE_AVG, d);
        `CHK(|d, 1'b1)
        i_host.read_reg(`REG_GR_AVG, d);
        `CHK(|d, 1'b1)
    endtask : t_skip
    task automatic t_line(input logic raw, vga, input int n_px);
        int t0, len, pv;
        do_reset(raw, vga, t0);
        len = 0;
        pv = 0;
        while (pix.line_valid !== 1'b1 && cyc - t0 < 30000) @(negedge sys_clk);
        while (pix.line_valid === 1'b1 && len < 4000) begin
            len++;
            if (pix.pix_valid === 1'b1) begin
                pv++;
                `CHK(pix.data, pix_in)
            end
            @(negedge sys_clk);
        end
        `CHK(pv, n_px)
        `CHK(len, raw ? n_px : 2 * n_px)
    endtask : t_line
    // ==================================================
    // main sequence and watchdog
    initial begin
        t_reset_map();
        t_regs();
        t_bad_id();
        t_skip();
        t_line(1'b1, 1'b0, 1280);
        t_line(1'b0, 1'b1, 640);
        wrap_up();
    end
    initial begin
        repeat (98000) @(posedge sys_clk);
        num_errors++;
        wrap_up();
    end
endmodule : tb_sensor_ctrl_regs_frame_out
